// ===== hw/tape_console_alarm_control.sv
// Console supervision: unload, displays, station lamps and error alarms
// Operation
// - Unload button rewinds, then releases door
// - Each display shows block being read, primary only while not recording
// - Primary shows write block; idle blanks display
// - Record lamp lit only while set to write
// - Read lamp lit only while set to read
// - Three write attempts on two areas
// - Write error locks, alarms, flashes write lamp
// - Tape end: alarm, advance, write end mark
// - Then reverse to last line, lamp off
// - Three read attempts, then lock and alarm
// - Clear after read error empties buffer, unlocks
// - Forward search miss starts reverse search
// - Target beyond end mark locks and alarms
// - Edit mode alarms on forbidden operator actions
// - End mark in edit mode leaves edit
// - Over 50 inserted characters locks and alarms
// - Edit alarms latch until clear key
// - Every error class sounds; only write, read, search and insert errors flash a lamp
// - Clear ends page lock, reloads line counter
`timescale 1ns/1ns
`default_nettype none

module tape_console_alarm_control
  import tape_console_pkg::*;
#(
  parameter int FLASH_HALF = FLASH_HALF_CYCLES
) (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  input  wire logic [1:0]         unload_btn_in,
  input  wire logic [1:0]         rewind_done_in,
  input  wire logic [1:0]         read_active_in,
  input  wire logic               write_active_in,
  input  wire logic [BLOCK_W-1:0] read_block0_in,
  input  wire logic [BLOCK_W-1:0] read_block1_in,
  input  wire logic [BLOCK_W-1:0] write_block_in,
  input  wire logic               record_mode_in,
  input  wire logic               play_mode_in,
  input  wire logic               search_mode_in,
  input  wire logic               write_fail_in,
  input  wire logic               write_ok_in,
  input  wire logic               read_fail_in,
  input  wire logic               read_ok_in,
  input  wire logic               near_tape_end_mark_in,
  input  wire logic               tape_end_in,
  input  wire logic               past_hole_in,
  input  wire logic               mark_written_in,
  input  wire logic               last_line_in,
  input  wire logic               search_miss_in,
  input  wire logic [BLOCK_W-1:0] target_block_in,
  input  wire logic [BLOCK_W-1:0] mark_block_in,
  input  wire logic               edit_enter_in,
  input  wire logic               end_of_recording_mark_in,
  input  wire logic               dup_select_in,
  input  wire logic               margin_select_in,
  input  wire logic               search_start_in,
  input  wire logic               char_insert_in,
  input  wire logic               line_done_in,
  input  wire logic               page_end_in,
  input  wire logic               alarm_clear_in,
  output logic [1:0]              rewind_out,
  output logic [1:0]              door_release_out,
  output logic [BLOCK_W-1:0]      display0_out,
  output logic [BLOCK_W-1:0]      display1_out,
  output logic [1:0]              display_blank_out,
  output logic                    record_lamp_out,
  output logic [1:0]              read_lamp_out,
  output logic                    write_mode_key_lamp_out,
  output logic                    readback_key_lamp_out,
  output logic                    seek_key_lamp_out,
  output logic                    edit_mode_key_lamp_out,
  output logic                    edit_mode_out,
  output logic                    alarm_out,
  output logic                    keyboard_lock_out,
  output logic                    playback_lock_out,
  output logic                    write_retry_out,
  output logic                    write_area_out,
  output logic                    read_retry_out,
  output logic                    reverse_search_out,
  output logic                    buffer_clear_out,
  output logic                    line_count_reload_out,
  output logic                    tape_advance_out,
  output logic                    write_mark_out,
  output logic                    tape_reverse_out
);

  localparam logic [FLASH_W-1:0] FLASH_LAST = FLASH_W'(FLASH_HALF - 1);

  typedef struct packed {
    end_state_e         end_st;
    logic [RETRY_W-1:0] wr_try;
    logic [RETRY_W-1:0] rd_try;
    logic [INSERT_W-1:0] ins_cnt;
    logic [FLASH_W-1:0] flash_cnt;
    logic               flash;
    logic               wr_err;
    logic               rd_err;
    logic               srch_err;
    logic               edit_ovf;
    logic               edit_alarm;
    logic               end_alarm;
    logic               end_done;
    logic               page_lock;
    logic               edit_mode;
    logic [BLOCK_W-1:0] disp0;
    logic [BLOCK_W-1:0] disp1;
    logic [1:0]         blank;
    logic               rec_lamp;
    logic [1:0]         rd_lamp;
    logic               wr_key;
    logic               rb_key;
    logic               seek_key;
    logic               edit_key;
    logic               alarm;
    logic               kb_lock;
    logic               pb_lock;
    logic               wr_retry;
    logic               wr_area;
    logic               rd_retry;
    logic               rev_search;
    logic               buf_clear;
    logic               lc_reload;
    logic               advance;
    logic               write_mark;
    logic               reverse;
  } console_s;

  console_s st;
  console_s next_st;

  logic [1:0] unload_start;

  function automatic logic last_try(input logic [RETRY_W-1:0] cnt,
                                    input logic [RETRY_W-1:0] tries);
    last_try = (cnt == tries - 2'h1);
  endfunction : last_try

  // Error overrides the steady indication with the flash phase
  function automatic logic key_lamp(input logic err,
                                    input logic phase,
                                    input logic steady);
    key_lamp = err ? phase : steady;
  endfunction : key_lamp

  // Rewinding is an edit-mode violation, so it is blocked there
  assign unload_start = unload_btn_in & {2{~st.edit_mode}};

  for (genvar i = 0; i < 2; i++) begin : g_unload
    unload_sequencer u_unload (
      .clk_sys_in       (clk_sys_in),
      .rst_n_in         (rst_n_in),
      .start_in         (unload_start[i]),
      .rewind_done_in   (rewind_done_in[i]),
      .rewind_out       (rewind_out[i]),
      .door_release_out (door_release_out[i])
    );
  end

  always_comb begin
    logic recording;
    logic locked;
    recording = 1'b0;
    locked    = 1'b0;
    next_st            = st;
    next_st.wr_retry   = 1'b0;
    next_st.rd_retry   = 1'b0;
    next_st.rev_search = 1'b0;
    next_st.buf_clear  = 1'b0;
    next_st.lc_reload  = 1'b0;

    // Flash phase runs free so all lamps blink in step
    if (st.flash_cnt == FLASH_LAST) begin
      next_st.flash_cnt = '0;
      next_st.flash     = ~st.flash;
    end else begin
      next_st.flash_cnt = st.flash_cnt + FLASH_W'(1);
    end

    // Clear first; events later in this process win over it
    if (alarm_clear_in) begin
      next_st.wr_err     = 1'b0;
      next_st.rd_err     = 1'b0;
      next_st.srch_err   = 1'b0;
      next_st.edit_ovf   = 1'b0;
      next_st.edit_alarm = 1'b0;
      next_st.end_alarm  = 1'b0;
      next_st.page_lock  = 1'b0;
      next_st.lc_reload  = 1'b1;
      next_st.wr_try     = '0;
      next_st.rd_try     = '0;
      next_st.wr_area    = 1'b0;
      next_st.ins_cnt    = '0;
      if (st.rd_err) begin
        next_st.buf_clear = 1'b1;
      end
    end

    if (page_end_in) begin
      next_st.page_lock = 1'b1;
    end

    // Write retries: first attempt on area A, the rest on area B
    if (write_ok_in) begin
      next_st.wr_try  = '0;
      next_st.wr_area = 1'b0;
    end else if (write_fail_in && !st.wr_err) begin
      if (last_try(next_st.wr_try, WRITE_TRIES)) begin
        next_st.wr_err  = 1'b1;
        next_st.wr_try  = '0;
        next_st.wr_area = 1'b0;
      end else begin
        next_st.wr_try   = next_st.wr_try + RETRY_W'(1);
        next_st.wr_retry = 1'b1;
        next_st.wr_area  = (next_st.wr_try >= WRITE_AREA_B_TRY);
      end
    end

    if (read_ok_in) begin
      next_st.rd_try = '0;
    end else if (read_fail_in && !st.rd_err) begin
      if (last_try(next_st.rd_try, READ_TRIES)) begin
        next_st.rd_err = 1'b1;
        next_st.rd_try = '0;
      end else begin
        next_st.rd_try   = next_st.rd_try + RETRY_W'(1);
        next_st.rd_retry = 1'b1;
      end
    end

    // BCD digits compare correctly as plain unsigned values
    if (search_miss_in) begin
      if (target_block_in > mark_block_in) begin
        next_st.srch_err = 1'b1;
      end else begin
        next_st.rev_search = 1'b1;
      end
    end

    // Tape end recovery while recording
    case (st.end_st)
      END_IDLE: begin
        if (record_mode_in && (near_tape_end_mark_in || tape_end_in)) begin
          next_st.end_st    = END_ADVANCE;
          next_st.end_alarm = 1'b1;
          next_st.advance   = 1'b1;
        end
      end
      END_ADVANCE: begin
        if (past_hole_in) begin
          next_st.end_st     = END_MARK;
          next_st.advance    = 1'b0;
          next_st.write_mark = 1'b1;
        end
      end
      END_MARK: begin
        if (mark_written_in) begin
          next_st.end_st     = END_REVERSE;
          next_st.write_mark = 1'b0;
          next_st.reverse    = 1'b1;
        end
      end
      END_REVERSE: begin
        if (last_line_in) begin
          next_st.end_st   = END_IDLE;
          next_st.reverse  = 1'b0;
          next_st.end_done = 1'b1;
        end
      end
      default: begin
        next_st.end_st     = END_IDLE;
        next_st.advance    = 1'b0;
        next_st.write_mark = 1'b0;
        next_st.reverse    = 1'b0;
      end
    endcase
    // Lamp stays off until record mode is left and re-entered
    if (!record_mode_in) begin
      next_st.end_done = 1'b0;
    end

    // Edit mode and its alarms
    if (edit_enter_in) begin
      next_st.edit_mode = 1'b1;
      next_st.ins_cnt   = '0;
    end
    if (st.edit_mode) begin
      if (dup_select_in || margin_select_in || search_start_in
          || (unload_btn_in != 2'h0)) begin
        next_st.edit_alarm = 1'b1;
      end
      if (line_done_in) begin
        next_st.ins_cnt = '0;
      end else if (char_insert_in && next_st.ins_cnt != INSERT_MAX) begin
        next_st.ins_cnt = next_st.ins_cnt + INSERT_W'(1);
        if (next_st.ins_cnt > INSERT_LIMIT) begin
          next_st.edit_ovf = 1'b1;
        end
      end
      if (end_of_recording_mark_in) begin
        next_st.edit_mode = 1'b0;
        next_st.ins_cnt   = '0;
      end
    end

    // Displays and station lamps
    recording = record_mode_in && write_active_in;
    next_st.disp0 = recording ? write_block_in : read_block0_in;
    next_st.disp1 = read_block1_in;
    next_st.blank[0] = !(recording || read_active_in[0]);
    next_st.blank[1] = !read_active_in[1];
    if (next_st.blank[0]) begin
      next_st.disp0 = BLOCK_BLANK;
    end
    if (next_st.blank[1]) begin
      next_st.disp1 = BLOCK_BLANK;
    end
    next_st.rec_lamp = write_active_in;
    next_st.rd_lamp  = read_active_in;

    // Key lamps follow the latches of this same cycle
    next_st.wr_key = key_lamp(next_st.wr_err, next_st.flash,
                              record_mode_in && !next_st.end_done);
    next_st.rb_key = key_lamp(next_st.rd_err, next_st.flash, play_mode_in);
    next_st.seek_key = key_lamp(next_st.srch_err, next_st.flash,
                                search_mode_in);
    next_st.edit_key = key_lamp(next_st.edit_ovf, next_st.flash,
                                next_st.edit_mode);

    // Sound comes from the lamp latches plus the edit and tape end alarms, which light no lamp
    next_st.alarm = next_st.wr_err || next_st.rd_err || next_st.srch_err
                    || next_st.edit_ovf || next_st.edit_alarm
                    || next_st.end_alarm;
    locked = next_st.wr_err || next_st.srch_err || next_st.page_lock;
    next_st.kb_lock = locked || next_st.rd_err || next_st.edit_ovf;
    next_st.pb_lock = locked;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign display0_out            = st.disp0;
  assign display1_out            = st.disp1;
  assign display_blank_out       = st.blank;
  assign record_lamp_out         = st.rec_lamp;
  assign read_lamp_out           = st.rd_lamp;
  assign write_mode_key_lamp_out = st.wr_key;
  assign readback_key_lamp_out   = st.rb_key;
  assign seek_key_lamp_out       = st.seek_key;
  assign edit_mode_key_lamp_out  = st.edit_key;
  assign edit_mode_out           = st.edit_mode;
  assign alarm_out               = st.alarm;
  assign keyboard_lock_out       = st.kb_lock;
  assign playback_lock_out       = st.pb_lock;
  assign write_retry_out         = st.wr_retry;
  assign write_area_out          = st.wr_area;
  assign read_retry_out          = st.rd_retry;
  assign reverse_search_out      = st.rev_search;
  assign buffer_clear_out        = st.buf_clear;
  assign line_count_reload_out   = st.lc_reload;
  assign tape_advance_out        = st.advance;
  assign write_mark_out          = st.write_mark;
  assign tape_reverse_out        = st.reverse;

endmodule : tape_console_alarm_control
`default_nettype wire

// ===== hw/tape_console_pkg.sv
// Shared constants and types for the tape console alarm and control logic
package tape_console_pkg;

  // Block address is two BCD digits
  localparam int              BLOCK_W           = 8;
  localparam logic [7:0]      BLOCK_BLANK       = 8'h00;

  // Line retry limits
  localparam int              RETRY_W           = 2;
  localparam logic [1:0]      WRITE_TRIES       = 2'h3;
  localparam logic [1:0]      READ_TRIES        = 2'h3;
  // Attempt index from which the second tape area is used
  localparam logic [1:0]      WRITE_AREA_B_TRY  = 2'h1;

  // Edit mode insertion limit
  localparam int              INSERT_W          = 6;
  localparam logic [5:0]      INSERT_LIMIT      = 6'h32;
  localparam logic [5:0]      INSERT_MAX        = 6'h3f;

  // Lamp flash timing
  localparam int              CLK_MHZ           = 250;
  localparam int              FLASH_HALF_MS     = 250;
  localparam int              FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_MHZ * 1000;
  localparam int              FLASH_W           = 26;

  typedef enum logic [1:0] {
    UNLOAD_IDLE,
    UNLOAD_REWIND,
    UNLOAD_RELEASE
  } unload_state_e;

  typedef enum logic [1:0] {
    END_IDLE,
    END_ADVANCE,
    END_MARK,
    END_REVERSE
  } end_state_e;

endpackage : tape_console_pkg

// ===== hw/unload_sequencer.sv
// Rewind then door release sequence for one tape transport
`timescale 1ns/1ns
`default_nettype none

module unload_sequencer
  import tape_console_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  input  wire logic rewind_done_in,
  output logic      rewind_out,
  output logic      door_release_out
);

  typedef struct packed {
    unload_state_e state;
    logic          rewind;
    logic          door;
  } unload_s;

  unload_s st;
  unload_s next_st;

  always_comb begin
    next_st         = st;
    next_st.door    = 1'b0;
    case (st.state)
      UNLOAD_IDLE: begin
        if (start_in) begin
          next_st.state  = UNLOAD_REWIND;
          next_st.rewind = 1'b1;
        end
      end
      UNLOAD_REWIND: begin
        // Door opens only after the rewind is reported complete
        if (rewind_done_in) begin
          next_st.state   = UNLOAD_RELEASE;
          next_st.rewind  = 1'b0;
          next_st.door    = 1'b1;
        end
      end
      UNLOAD_RELEASE: begin
        next_st.state = UNLOAD_IDLE;
      end
      default: begin
        next_st = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rewind_out       = st.rewind;
  assign door_release_out = st.door;

endmodule : unload_sequencer
`default_nettype wire

// ===== tb/tape_transport_model.sv
// Behavioural model of the two tape transports answering rewind requests
`timescale 1ns/1ns
`default_nettype none

module tape_transport_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] rewind_in,
  input  wire logic [3:0] delay_in,
  output logic      [1:0] rewind_done_out
);
  logic [3:0] cnt [2];

  // Done is low whenever no rewind runs, so a stale report cannot leak
  for (genvar i = 0; i < 2; i++) begin : g_tr
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        cnt[i] <= 4'h0;
      end else begin
        cnt[i] <= rewind_in[i] ? cnt[i] + 4'h1 : 4'h0;
      end
    end
  end
  assign rewind_done_out = rewind_in & {cnt[1] == delay_in, cnt[0] == delay_in};
endmodule : tape_transport_model

`default_nettype wire

// ===== tb/tape_console_alarm_control_sva.sv
// Port level assertions for the console alarm control
`timescale 1ns/1ns
`default_nettype none

module tape_console_sva
  import tape_console_pkg::*;
#(
  parameter int FLASH_HALF = 4
) (
  input wire logic               clk_sys_in,
  input wire logic               rst_n_in,
  input wire logic [1:0]         unload_btn_in,
  input wire logic [1:0]         rewind_done_in,
  input wire logic [1:0]         read_active_in,
  input wire logic [BLOCK_W-1:0] read_block1_in,
  input wire logic               write_fail_in,
  input wire logic               write_ok_in,
  input wire logic               read_fail_in,
  input wire logic               read_ok_in,
  input wire logic               past_hole_in,
  input wire logic               mark_written_in,
  input wire logic               search_miss_in,
  input wire logic [BLOCK_W-1:0] target_block_in,
  input wire logic [BLOCK_W-1:0] mark_block_in,
  input wire logic               alarm_clear_in,
  input wire logic [1:0]         rewind_out,
  input wire logic [1:0]         door_release_out,
  input wire logic [BLOCK_W-1:0] display1_out,
  input wire logic               edit_mode_out,
  input wire logic               alarm_out,
  input wire logic               keyboard_lock_out,
  input wire logic               playback_lock_out,
  input wire logic               write_retry_out,
  input wire logic               reverse_search_out,
  input wire logic               line_count_reload_out,
  input wire logic               tape_advance_out,
  input wire logic               write_mark_out,
  input wire logic               tape_reverse_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // Attempt mirrors saturate, so fails after a latched error stay quiet
  logic [1:0] wf_cnt;
  logic [1:0] rf_cnt;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wf_cnt <= 2'h0;
      rf_cnt <= 2'h0;
    end else begin
      if (write_ok_in || alarm_clear_in) wf_cnt <= 2'h0;
      else if (write_fail_in && wf_cnt != 2'h3) wf_cnt <= wf_cnt + 2'h1;
      if (read_ok_in || alarm_clear_in) rf_cnt <= 2'h0;
      else if (read_fail_in && rf_cnt != 2'h3) rf_cnt <= rf_cnt + 2'h1;
    end
  end

  sequence done_seen(int i);
    rewind_out[i] && rewind_done_in[i];
  endsequence
  sequence hole_seen;
    tape_advance_out && past_hole_in;
  endsequence
  sequence mark_seen;
    write_mark_out && mark_written_in;
  endsequence

  chk_unload_start: assert property (unload_btn_in[0] && rewind_out == 2'h0 &&
    !door_release_out[0] && !edit_mode_out |=> rewind_out[0]) else $error("no rewind");
  chk_door_release: assert property (done_seen(1) |=> !rewind_out[1] &&
    door_release_out[1] ##1 !door_release_out[1]) else $error("bad door release");
  chk_display_idle: assert property (display1_out == ($past(read_active_in[1]) ?
    $past(read_block1_in) : BLOCK_BLANK)) else $error("bad display");
  chk_write_retry: assert property (write_fail_in && wf_cnt < 2'h2 &&
    !alarm_clear_in |=> write_retry_out) else $error("no write retry");
  chk_write_error: assert property (write_fail_in && wf_cnt == 2'h2 &&
    !alarm_clear_in |=> alarm_out && keyboard_lock_out && playback_lock_out)
    else $error("no write error");
  chk_read_error: assert property (read_fail_in && rf_cnt == 2'h2 &&
    !alarm_clear_in |=> alarm_out && keyboard_lock_out) else $error("no read error");
  chk_search_lock: assert property (search_miss_in && target_block_in > mark_block_in
    |=> alarm_out && keyboard_lock_out && !reverse_search_out) else $error("no seek lock");
  chk_search_reverse: assert property (search_miss_in &&
    target_block_in <= mark_block_in |=> reverse_search_out) else $error("no reverse");
  chk_end_advance: assert property (hole_seen |=>
    write_mark_out && !tape_advance_out) else $error("bad hole step");
  chk_end_reverse: assert property (mark_seen |=>
    tape_reverse_out && !write_mark_out) else $error("bad mark step");
  chk_clear_reload: assert property (alarm_clear_in |=>
    line_count_reload_out) else $error("no reload");
endmodule : tape_console_sva

bind tape_console_alarm_control tape_console_sva #(.FLASH_HALF(FLASH_HALF)) chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .unload_btn_in(unload_btn_in),
  .rewind_done_in(rewind_done_in), .read_active_in(read_active_in),
  .read_block1_in(read_block1_in), .write_fail_in(write_fail_in),
  .write_ok_in(write_ok_in), .read_fail_in(read_fail_in), .read_ok_in(read_ok_in),
  .past_hole_in(past_hole_in), .mark_written_in(mark_written_in),
  .search_miss_in(search_miss_in), .target_block_in(target_block_in),
  .mark_block_in(mark_block_in), .alarm_clear_in(alarm_clear_in),
  .rewind_out(rewind_out), .door_release_out(door_release_out),
  .display1_out(display1_out), .edit_mode_out(edit_mode_out), .alarm_out(alarm_out),
  .keyboard_lock_out(keyboard_lock_out), .playback_lock_out(playback_lock_out),
  .write_retry_out(write_retry_out), .reverse_search_out(reverse_search_out),
  .line_count_reload_out(line_count_reload_out), .tape_advance_out(tape_advance_out),
  .write_mark_out(write_mark_out), .tape_reverse_out(tape_reverse_out)
);

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the console alarm control
`timescale 1ns/1ns
`default_nettype none

module tb
  import tape_console_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [20:0] ev         = '0;
  logic [1:0]  ra         = 2'h0;
  logic        wa         = 1'b0;
  logic        rm         = 1'b0;
  logic        ps         = 1'b0;
  logic [7:0]  tgt        = 8'h00;
  logic [7:0]  mk         = 8'h00;
  logic [3:0]  dly        = 4'h0;
  logic [1:0]  rdone, rew, rel, blank, rlamp;
  logic [7:0]  d0, d1;
  logic        write_mode_key_lamp, wk, rk, sk, ek, edm, alm, kl, pl, wr, war, rr, rvs, bc, lcr;
  logic        adv, wmk, trv;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          fb [4] = '{12, 13, 14, 19};
  wire  [3:0]  lamps = {ek, sk, rk, wk};

  always #2 clk_sys_in = ~clk_sys_in;

  tape_transport_model tr (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .rewind_in(rew), .delay_in(dly), .rewind_done_out(rdone));

  // Short flash half period keeps the lamp checks a few cycles long
  tape_console_alarm_control #(.FLASH_HALF(4)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .unload_btn_in(ev[20:19]),
    .rewind_done_in(rdone), .read_active_in(ra), .write_active_in(wa),
    .read_block0_in(8'h99), .read_block1_in(8'h17), .write_block_in(8'h42),
    .record_mode_in(rm), .play_mode_in(ps), .search_mode_in(ps),
    .write_fail_in(ev[0]), .write_ok_in(ev[1]), .read_fail_in(ev[2]),
    .read_ok_in(ev[3]), .near_tape_end_mark_in(ev[4]), .tape_end_in(ev[5]),
    .past_hole_in(ev[6]), .mark_written_in(ev[7]), .last_line_in(ev[8]),
    .search_miss_in(ev[9]), .target_block_in(tgt), .mark_block_in(mk),
    .edit_enter_in(ev[10]), .end_of_recording_mark_in(ev[11]), .dup_select_in(ev[12]),
    .margin_select_in(ev[13]), .search_start_in(ev[14]), .char_insert_in(ev[15]),
    .line_done_in(ev[16]), .page_end_in(ev[17]), .alarm_clear_in(ev[18]),
    .rewind_out(rew), .door_release_out(rel), .display0_out(d0), .display1_out(d1),
    .display_blank_out(blank), .record_lamp_out(write_mode_key_lamp), .read_lamp_out(rlamp),
    .write_mode_key_lamp_out(wk), .readback_key_lamp_out(rk), .seek_key_lamp_out(sk),
    .edit_mode_key_lamp_out(ek), .edit_mode_out(edm), .alarm_out(alm),
    .keyboard_lock_out(kl), .playback_lock_out(pl), .write_retry_out(wr),
    .write_area_out(war), .read_retry_out(rr), .reverse_search_out(rvs),
    .buffer_clear_out(bc), .line_count_reload_out(lcr), .tape_advance_out(adv),
    .write_mark_out(wmk), .tape_reverse_out(trv));

  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask : step

  // Leading step keeps two pulses from touching the vector in one time step
  task automatic pulse(input int i);
    step();
    ev = 21'h1 << i;
    step();
    ev = '0;
  endtask : pulse

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic flash(input int k);
    logic [1:0] seen;
    seen = 2'h0;
    repeat (16) begin
      step();
      seen[lamps[k]] = 1'b1;
    end
    chk(seen, 8'h03);
  endtask : flash

  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic wait_rel(input int i);
    int n;
    n = 0;
    while (rel[i] !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    if (rel[i] !== 1'b1) begin
      num_errors++;
      $display("BAD at %0t: no door release", $time);
      test_done();
    end
  endtask : wait_rel

  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'b1;
    wa = 1'b1;
    rm = 1'b1;
    ra = 2'h2;
    ps = 1'b1;
    step();
    step();
    chk({write_mode_key_lamp, rlamp, wk}, 8'h0d);
    chk({rk, sk}, 8'h03);
    chk(d0, 8'h42);
    chk(d1, 8'h17);
    chk(blank, 8'h00);
    wa = 1'b0;
    rm = 1'b0;
    ra = 2'h1;
    ps = 1'b0;
    step();
    step();
    chk({write_mode_key_lamp, rlamp, rk, sk}, 8'h04);
    chk({d0, d1, 6'h0, blank}, 24'h990002);
    ra = 2'h0;
    step();
    step();
    chk({d0, 6'h0, blank}, 16'h0003);
    $display("test lamps done");
    for (int i = 0; i < 2; i++) begin
      dly = i ? 4'h6 : 4'h0;
      pulse(19 + i);
      chk(rew, 8'(1 << i));
      wait_rel(i);
      chk(rew, 8'h00);
    end
    $display("test unload done");
    for (int k = 0; k < 2; k++) begin
      pulse(0);
      chk({wr, war, alm}, 8'h06);
    end
    pulse(0);
    chk({alm, kl, pl}, 8'h07);
    flash(0);
    pulse(18);
    chk({alm, kl, pl, lcr}, 8'h01);
    pulse(0);
    pulse(1);
    chk(war, 8'h00);
    pulse(0);
    pulse(0);
    chk(alm, 8'h00);
    $display("test write done");
    for (int k = 0; k < 2; k++) begin
      pulse(2);
      chk(rr, 8'h01);
    end
    pulse(2);
    chk({alm, kl, pl}, 8'h06);
    flash(1);
    pulse(18);
    chk({bc, alm, kl}, 8'h04);
    $display("test read done");
    tgt = 8'h25;
    mk = 8'h20;
    pulse(9);
    chk({alm, kl, pl, rvs}, 8'h0e);
    flash(2);
    pulse(18);
    tgt = 8'h20;
    pulse(9);
    chk({alm, rvs}, 8'h01);
    $display("test search done");
    for (int k = 0; k < 2; k++) begin
      rm = 1'b1;
      pulse(4 + k);
      chk({alm, adv}, 8'h03);
      pulse(6);
      chk({adv, wmk}, 8'h01);
      pulse(7);
      chk({wmk, trv}, 8'h01);
      pulse(8);
      chk({trv, wk}, 8'h00);
      pulse(18);
      rm = 1'b0;
      step();
    end
    $display("test tape end done");
    pulse(10);
    chk({edm, ek}, 8'h03);
    foreach (fb[k]) begin
      pulse(fb[k]);
      chk({alm, kl, rew[0]}, 8'h04);
      step();
      chk(alm, 8'h01);
      pulse(18);
      chk(alm, 8'h00);
    end
    repeat (30) pulse(15);
    pulse(16);
    repeat (50) pulse(15);
    chk({alm, kl}, 8'h00);
    pulse(15);
    chk({alm, kl}, 8'h03);
    flash(3);
    pulse(18);
    chk({alm, kl}, 8'h00);
    pulse(11);
    chk({edm, ek}, 8'h00);
    $display("test edit done");
    pulse(17);
    chk({kl, pl}, 8'h03);
    pulse(18);
    chk({kl, pl, lcr}, 8'h01);
    $display("test page end done");
    test_done();
  end
endmodule : tb

`default_nettype wire
